// File: pin_wake_map.vh
// Constants for the power pin and wake control block
`ifndef PIN_WAKE_MAP_VH
`define PIN_WAKE_MAP_VH
`define WAKE_PIN_COUNT 35
`define WAKE_PIN_MASK_ALL 35'h7ffffffff
`define WAKE_PIN_MASK_FAULT 35'h000000003
`define FAULT_CTRL_WIDTH 2
`define FAULT_CTRL_FORCE 2'h0
`define MODE_RUN 3'h0
`define MODE_STANDBY 3'h1
`define MODE_SLEEP 3'h2
`define MODE_DEEP_SLEEP 3'h3
`define DEBUG_DIV_HALF 3'h3
`define DEBUG_DIV_WIDTH 3
`define GPIO_IDX_PULL_UP 2
`endif

// File: input_sync3.v
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module input_sync3 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)
(
  input wire clock_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // Stage1 feeds only stage2; output moves once stages 2 and 3 agree
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      sync_o <= RESET_VALUE;
    end
    else
    begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1)
      begin
        if (stage2[i] == stage3[i])
          sync_o[i] <= stage3[i];
      end
    end
  end
endmodule

// File: debug_clock_divider.v
// Divider that derives the debug clock output from the peripheral clock
`timescale 1ns/1ps
`include "pin_wake_map.vh"
module debug_clock_divider
(
  input wire clock_i,
  input wire rst_n_i,
  input wire enable_i,
  output reg debug_clock_o
);
  reg [`DEBUG_DIV_WIDTH-1:0] count;

  // Divide by twice the half period; output held low when disabled
  always @(posedge clock_i)
  begin
    if (!rst_n_i || !enable_i)
    begin
      count <= {`DEBUG_DIV_WIDTH{1'b0}};
      debug_clock_o <= 1'b0;
    end
    else if (count == `DEBUG_DIV_HALF - 3'h1)
    begin
      count <= {`DEBUG_DIV_WIDTH{1'b0}};
      debug_clock_o <= ~debug_clock_o; // [RULE_19]
    end
    else
      count <= count + 3'h1;
  end
endmodule

// File: power_pin_wake_control.v
// Pin level control for wake sources, fault entry, supply enables and pin sharing
//
// How it works
// RULE_01 - Fixed set of thirty-five GPIO pins can wake from standby and sleep.
// RULE_02 - Wake pin pulls on during resets, off when hold bit is cleared.
// RULE_03 - GPIO 3 wakes standby, sleep and deep sleep; its pull-up behaves likewise.
// RULE_04 - After fault-caused deep sleep, only GPIO 1 and 0 wake the device.
// RULE_05 - Software keeps GPIO 0 or 1 an input when relying on faults.
// RULE_06 - With pin reset enabled, GPIO 1 becomes an active-low reset request.
// RULE_07 - Clock select set: ignore oscillator pad, use bidirectional clock pin.
// RULE_08 - Bidirectional clock pin drives or takes clock; else stays GPIO 9.
// RULE_09 - Slow clock output copies timekeeping clock when enabled, else GPIO 10.
// RULE_10 - In deep sleep with slow clock output enabled, hold it low.
// RULE_11 - Slow clock pin pull-down on in resets, off when hold bit clears.
// RULE_12 - Clock request pin is sampled only during power-on or hardware reset.
// RULE_13 - External clock usable by peripherals; blocked in standby/sleep with timer running.
// RULE_14 - Low battery or supply fault forces deep sleep when fault control is zero.
// RULE_15 - Core supply enable high when needed, dropped on sleep or deep sleep.
// RULE_16 - System supply enable high, dropped only on deep sleep entry.
// RULE_17 - Power bus clock takes over GPIO 3 only when power bus enabled.
// RULE_18 - Power bus data takes over GPIO 4 only when power bus enabled.
// RULE_19 - Debug clock output is a divided-down peripheral clock.
// RULE_20 - Reset out also asserted during pin reset unless disable bit set.
// RULE_21 - Fault inputs and wake pins are synchronised before use.
`timescale 1ns/1ps
`include "pin_wake_map.vh"
module power_pin_wake_control
(
  input wire clock_i,
  input wire rst_n_i,
  // Reset kinds from the reset manager (pulls come on for reset_any_i)
  input wire reset_any_i,
  input wire reset_hard_i,
  input wire [2:0] mode_request_i,
  input wire mode_request_valid_i,
  // Configuration bits from software
  input wire hold_pull_resistors_clear_i,
  input wire pin_reset_enable_i,
  input wire pin_reset_out_disable_i,
  input wire clock_from_pad_select_i,
  input wire clock_pin_enable_i,
  input wire slow_clock_out_enable_i,
  input wire power_bus_enable_i,
  input wire [`FAULT_CTRL_WIDTH-1:0] fault_handling_control_i,
  input wire [`WAKE_PIN_COUNT-1:0] wake_enable_i,
  input wire os_timer_running_i,
  input wire debug_clock_enable_i,
  // Pins
  input wire [`WAKE_PIN_COUNT-1:0] wake_pins_i,
  input wire gpio1_pin_i,
  input wire battery_fault_n_i,
  input wire supply_fault_n_i,
  input wire clock_request_i,
  input wire primary_osc_input_i,
  input wire bidir_processor_clock_i,
  input wire slow_osc_input_i,
  input wire external_clock_input_i,
  input wire gpio9_out_i,
  input wire gpio9_oe_n_i,
  input wire gpio10_out_i,
  input wire gpio10_oe_n_i,
  input wire gpio3_out_i,
  input wire gpio3_oe_n_i,
  input wire gpio4_out_i,
  input wire gpio4_oe_n_i,
  input wire power_bus_clock_out_i,
  input wire power_bus_clock_oe_n_i,
  input wire power_bus_data_out_i,
  input wire power_bus_data_oe_n_i,
  input wire power_bus_clock_pin_i,
  input wire power_bus_data_pin_i,
  // Outputs
  output reg [2:0] power_mode_o,
  output reg wake_event_o,
  output reg fault_wake_only_o,
  output reg hold_pull_resistors_o,
  output reg wake_pulls_enable_o,
  output reg slow_clock_pull_down_o,
  output reg pin_reset_request_o,
  output reg gpio1_to_gpio_o,
  output reg reset_out_n_o,
  output reg processor_osc_clock_o,
  output reg bidir_processor_clock_o,
  output reg bidir_processor_clock_oe_n_o,
  output reg gpio9_pin_o,
  output reg gpio9_pin_oe_n_o,
  output reg slow_clock_out_o,
  output reg slow_clock_out_oe_n_o,
  output reg clock_source_pad_o,
  output reg external_clock_usable_o,
  output reg core_supply_enable_o,
  output reg system_supply_enable_o,
  output reg power_bus_clock_o,
  output reg power_bus_clock_oe_n_o,
  output reg power_bus_data_o,
  output reg power_bus_data_oe_n_o,
  output reg power_bus_clock_in_o,
  output reg power_bus_data_in_o,
  output reg gpio3_in_o,
  output reg gpio4_in_o,
  output wire debug_clock_out_o
);
  wire [`WAKE_PIN_COUNT-1:0] wake_sync;
  wire [1:0] fault_sync_n;
  wire gpio1_sync;
  reg [`WAKE_PIN_COUNT-1:0] wake_prev;
  reg fault_entry;
  reg [2:0] next_mode;
  wire fault_active;
  wire [`WAKE_PIN_COUNT-1:0] wake_allowed;
  wire [`WAKE_PIN_COUNT-1:0] wake_rise;
  wire wake_hit;
  wire sleeping;

  // Pin inputs cross into the processor clock domain
  input_sync3 #(.WIDTH(`WAKE_PIN_COUNT)) u_wake_sync
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(wake_pins_i),
    .sync_o(wake_sync) // [RULE_21]
  );

  // Fault pins idle high, so reset the filter high
  input_sync3 #(.WIDTH(2), .RESET_VALUE(2'h3)) u_fault_sync
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({battery_fault_n_i, supply_fault_n_i}),
    .sync_o(fault_sync_n) // [RULE_21]
  );

  input_sync3 #(.WIDTH(1), .RESET_VALUE(1'b1)) u_gpio1_sync
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(gpio1_pin_i),
    .sync_o(gpio1_sync)
  );

  debug_clock_divider u_debug_div
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .enable_i(debug_clock_enable_i),
    .debug_clock_o(debug_clock_out_o) // [RULE_19]
  );

  // Faults are ignored while any reset is in progress
  assign fault_active = ~reset_any_i & (~fault_sync_n[0] | ~fault_sync_n[1]);
  assign sleeping = (power_mode_o != `MODE_RUN);
  // GPIO 3 (index 2) is the only listed pin beyond 0 and 1 that reaches deep sleep
  assign wake_allowed = fault_entry ? `WAKE_PIN_MASK_FAULT : // [RULE_04]
    (power_mode_o == `MODE_DEEP_SLEEP) ? (`WAKE_PIN_MASK_FAULT | (35'h1 << `GPIO_IDX_PULL_UP)) : // [RULE_03]
    `WAKE_PIN_MASK_ALL; // [RULE_01]
  assign wake_rise = wake_sync & ~wake_prev;
  assign wake_hit = |(wake_rise & wake_allowed & wake_enable_i);

  // Mode selection; a fault wins over a wake in the same cycle
  always @*
  begin
    next_mode = power_mode_o;
    if (fault_active && fault_handling_control_i == `FAULT_CTRL_FORCE)
      next_mode = `MODE_DEEP_SLEEP; // [RULE_14]
    else if (sleeping && wake_hit)
      next_mode = `MODE_RUN;
    else if (!sleeping && mode_request_valid_i)
      next_mode = mode_request_i;
  end

  // Mode register, fault-entry memory and wake event
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      power_mode_o <= `MODE_RUN;
      fault_entry <= 1'b0;
      wake_prev <= {`WAKE_PIN_COUNT{1'b0}};
      wake_event_o <= 1'b0;
      fault_wake_only_o <= 1'b0;
    end
    else
    begin
      case (next_mode)
        `MODE_RUN, `MODE_STANDBY, `MODE_SLEEP, `MODE_DEEP_SLEEP:
          power_mode_o <= next_mode;
        default:
          power_mode_o <= power_mode_o;
      endcase
      wake_prev <= wake_sync;
      wake_event_o <= sleeping && wake_hit && next_mode == `MODE_RUN;
      // Re-entry by fault keeps the restriction; a clean wake drops it
      if (next_mode == `MODE_DEEP_SLEEP && fault_active && fault_handling_control_i == `FAULT_CTRL_FORCE)
        fault_entry <= 1'b1; // [RULE_04]
      else if (next_mode == `MODE_RUN)
        fault_entry <= 1'b0;
      fault_wake_only_o <= (next_mode == `MODE_DEEP_SLEEP && fault_active) ||
        (fault_entry && next_mode != `MODE_RUN);
    end
  end

  // Pull hold: set by any reset, released by software; reset wins over clear
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
      hold_pull_resistors_o <= 1'b1;
    else if (reset_any_i)
      hold_pull_resistors_o <= 1'b1; // [RULE_02] [RULE_11]
    else if (hold_pull_resistors_clear_i)
      hold_pull_resistors_o <= 1'b0;
  end

  // Pull controls follow the hold bit one cycle later; a reset turns them on at the same edge as the hold bit
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wake_pulls_enable_o <= 1'b1;
      slow_clock_pull_down_o <= 1'b1;
    end
    else
    begin
      wake_pulls_enable_o <= hold_pull_resistors_o | reset_any_i; // [RULE_02] [RULE_03]
      slow_clock_pull_down_o <= hold_pull_resistors_o | reset_any_i; // [RULE_11]
    end
  end

  // Pin reset function on GPIO 1 and reset-out indication
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pin_reset_request_o <= 1'b0;
      gpio1_to_gpio_o <= 1'b1;
      reset_out_n_o <= 1'b0;
    end
    else
    begin
      pin_reset_request_o <= pin_reset_enable_i & ~gpio1_sync; // [RULE_06]
      gpio1_to_gpio_o <= ~pin_reset_enable_i; // [RULE_06]
      // Software usually never sees this low: the reset manager holds it
      reset_out_n_o <= ~((pin_reset_enable_i & ~gpio1_sync & ~pin_reset_out_disable_i) | reset_hard_i); // [RULE_20]
    end
  end

  // Clock source strap: caught only while hard reset is held
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
      clock_source_pad_o <= 1'b1;
    else if (reset_hard_i)
      clock_source_pad_o <= ~clock_request_i; // [RULE_12]
  end

  // Clock muxing is registered; fine for these slow pad rates only
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      processor_osc_clock_o <= 1'b0;
      bidir_processor_clock_o <= 1'b0;
      bidir_processor_clock_oe_n_o <= 1'b1;
      gpio9_pin_o <= 1'b0;
      gpio9_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      processor_osc_clock_o <= clock_from_pad_select_i ? bidir_processor_clock_i : primary_osc_input_i; // [RULE_07]
      if (clock_from_pad_select_i)
      begin
        bidir_processor_clock_o <= 1'b0;
        bidir_processor_clock_oe_n_o <= 1'b1; // [RULE_08]
      end
      else if (clock_pin_enable_i)
      begin
        bidir_processor_clock_o <= primary_osc_input_i;
        bidir_processor_clock_oe_n_o <= 1'b0; // [RULE_08]
      end
      else
      begin
        bidir_processor_clock_o <= 1'b0;
        bidir_processor_clock_oe_n_o <= 1'b1;
      end
      gpio9_pin_o <= gpio9_out_i;
      gpio9_pin_oe_n_o <= (clock_pin_enable_i | clock_from_pad_select_i) ? 1'b1 : gpio9_oe_n_i; // [RULE_08]
    end
  end

  // Slow clock output shares the GPIO 10 pin
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      slow_clock_out_o <= 1'b0;
      slow_clock_out_oe_n_o <= 1'b1;
    end
    else if (slow_clock_out_enable_i)
    begin
      slow_clock_out_oe_n_o <= 1'b0;
      slow_clock_out_o <= (power_mode_o == `MODE_DEEP_SLEEP) ? 1'b0 : slow_osc_input_i; // [RULE_09] [RULE_10]
    end
    else
    begin
      slow_clock_out_o <= gpio10_out_i; // [RULE_09]
      slow_clock_out_oe_n_o <= gpio10_oe_n_i;
    end
  end

  // External clock gate while the OS timer runs in standby or sleep
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
      external_clock_usable_o <= 1'b0;
    else
      external_clock_usable_o <= ~(os_timer_running_i &&
        (power_mode_o == `MODE_STANDBY || power_mode_o == `MODE_SLEEP)); // [RULE_13]
  end

  // Supply enables are registered from next_mode, so they change on the same edge as the mode register
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      core_supply_enable_o <= 1'b1;
      system_supply_enable_o <= 1'b1;
    end
    else
    begin
      core_supply_enable_o <= ~(next_mode == `MODE_SLEEP || next_mode == `MODE_DEEP_SLEEP); // [RULE_15]
      system_supply_enable_o <= ~(next_mode == `MODE_DEEP_SLEEP); // [RULE_16]
    end
  end

  // Power bus pins take GPIO 3 and 4 only when enabled
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      power_bus_clock_o <= 1'b0;
      power_bus_clock_oe_n_o <= 1'b1;
      power_bus_data_o <= 1'b0;
      power_bus_data_oe_n_o <= 1'b1;
      power_bus_clock_in_o <= 1'b1;
      power_bus_data_in_o <= 1'b1;
      gpio3_in_o <= 1'b1;
      gpio4_in_o <= 1'b1;
    end
    else
    begin
      power_bus_clock_o <= power_bus_enable_i ? power_bus_clock_out_i : gpio3_out_i; // [RULE_17]
      power_bus_clock_oe_n_o <= power_bus_enable_i ? power_bus_clock_oe_n_i : gpio3_oe_n_i; // [RULE_17]
      power_bus_data_o <= power_bus_enable_i ? power_bus_data_out_i : gpio4_out_i; // [RULE_18]
      power_bus_data_oe_n_o <= power_bus_enable_i ? power_bus_data_oe_n_i : gpio4_oe_n_i; // [RULE_18]
      power_bus_clock_in_o <= power_bus_enable_i ? power_bus_clock_pin_i : 1'b1;
      power_bus_data_in_o <= power_bus_enable_i ? power_bus_data_pin_i : 1'b1;
      gpio3_in_o <= power_bus_enable_i ? 1'b1 : power_bus_clock_pin_i;
      gpio4_in_o <= power_bus_enable_i ? 1'b1 : power_bus_data_pin_i;
    end
  end
endmodule

// File: power_pin_wake_control_asserts.sv
// Concurrent checks on the pins of the power pin and wake control block
`timescale 1ns/1ps
`include "pin_wake_map.vh"
module power_pin_wake_control_asserts
(
  input wire clock_i,
  input wire rst_n_i,
  input wire reset_any_i,
  input wire hold_pull_resistors_clear_i,
  input wire pin_reset_enable_i,
  input wire pin_reset_out_disable_i,
  input wire clock_from_pad_select_i,
  input wire clock_pin_enable_i,
  input wire slow_clock_out_enable_i,
  input wire power_bus_enable_i,
  input wire [`FAULT_CTRL_WIDTH-1:0] fault_handling_control_i,
  input wire battery_fault_n_i,
  input wire [2:0] power_mode_o,
  input wire wake_event_o,
  input wire hold_pull_resistors_o,
  input wire wake_pulls_enable_o,
  input wire slow_clock_pull_down_o,
  input wire pin_reset_request_o,
  input wire gpio1_to_gpio_o,
  input wire reset_out_n_o,
  input wire gpio9_pin_oe_n_o,
  input wire slow_clock_out_o,
  input wire core_supply_enable_o,
  input wire system_supply_enable_o,
  input wire power_bus_clock_in_o,
  input wire power_bus_data_in_o
);
  // One clock domain, so a single default clocking and disable
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  deep_supplies_a: assert property (power_mode_o == `MODE_DEEP_SLEEP |->
    !core_supply_enable_o && !system_supply_enable_o) else $error("supplies on in deep sleep");
  sleep_supplies_a: assert property (power_mode_o == `MODE_SLEEP |->
    !core_supply_enable_o && system_supply_enable_o) else $error("wrong supplies in sleep");
  run_supplies_a: assert property (power_mode_o == `MODE_RUN |->
    core_supply_enable_o && system_supply_enable_o) else $error("supply off in run");
  // Fault seen in run must land in deep sleep within the synchroniser lag
  fault_entry_a: assert property ($fell(battery_fault_n_i) && !reset_any_i &&
    fault_handling_control_i == `FAULT_CTRL_FORCE && power_mode_o == `MODE_RUN
    |-> ##[1:6] power_mode_o == `MODE_DEEP_SLEEP) else $error("fault did not force deep sleep");
  hold_clear_a: assert property (hold_pull_resistors_clear_i && !reset_any_i |=>
    !hold_pull_resistors_o ##1 (!wake_pulls_enable_o && !slow_clock_pull_down_o)) else $error("pulls not released");
  reset_pulls_a: assert property (reset_any_i |-> ##[1:2]
    (wake_pulls_enable_o && slow_clock_pull_down_o)) else $error("pulls off during reset");
  deep_clock_low_a: assert property (power_mode_o == `MODE_DEEP_SLEEP && $past(power_mode_o) == 3'h3 &&
    slow_clock_out_enable_i && $past(slow_clock_out_enable_i) |-> !slow_clock_out_o) else $error("slow clock moves");
  gpio9_owned_a: assert property ($past(clock_pin_enable_i) || $past(clock_from_pad_select_i) |->
    gpio9_pin_oe_n_o) else $error("gpio drives clock pin");
  bus_released_a: assert property (!$past(power_bus_enable_i) |->
    power_bus_clock_in_o && power_bus_data_in_o) else $error("power bus sees pins while off");
  gpio1_plain_a: assert property (!$past(pin_reset_enable_i) |->
    !pin_reset_request_o && gpio1_to_gpio_o) else $error("pin reset while disabled");
  reset_out_a: assert property (pin_reset_request_o && !$past(pin_reset_out_disable_i) |->
    !reset_out_n_o) else $error("reset out not asserted");
  // Wake pulse only on the edge that leaves a low power mode
  wake_event_a: assert property (wake_event_o |-> power_mode_o == `MODE_RUN &&
    $past(power_mode_o) != `MODE_RUN) else $error("wake pulse outside a wake");

  // Main scenarios reached
  fault_entry_c: cover property (!battery_fault_n_i && power_mode_o == `MODE_DEEP_SLEEP);
  sleep_seen_c: cover property (power_mode_o == `MODE_SLEEP);
  pin_reset_c: cover property (pin_reset_request_o && !reset_out_n_o);
endmodule
bind power_pin_wake_control power_pin_wake_control_asserts u_asserts (.*);

// File: board_partner_model.sv
// Board side model of the fault comparators and the timekeeping oscillator
`timescale 1ns/1ps
module board_partner_model
(
  input wire clock_i,
  input wire battery_low_i,
  input wire supply_bad_i,
  output reg battery_fault_n_o,
  output reg supply_fault_n_o,
  output reg slow_osc_o
);
  // Comparators idle high, so no fault is seen before the bench asks for one
  initial
  begin
    battery_fault_n_o = 1'b1;
    supply_fault_n_o = 1'b1;
    slow_osc_o = 1'b0;
  end
  // Oscillator runs free and fast so its copy on the pin can be seen moving
  always @(posedge clock_i)
  begin
    battery_fault_n_o <= #3 ~battery_low_i;
    supply_fault_n_o <= #3 ~supply_bad_i;
    slow_osc_o <= #3 ~slow_osc_o;
  end
endmodule

// File: power_pin_wake_control_tb.sv
// Self-checking bench for the power pin and wake control block
`timescale 1ns/1ps
`include "pin_wake_map.vh"
module power_pin_wake_control_tb;
  reg clock_i, rst_n_i, reset_any_i, reset_hard_i, mode_request_valid_i, hold_pull_resistors_clear_i;
  reg pin_reset_enable_i, pin_reset_out_disable_i, clock_from_pad_select_i, clock_pin_enable_i;
  reg slow_clock_out_enable_i, power_bus_enable_i, os_timer_running_i, debug_clock_enable_i, gpio1_pin_i;
  reg clock_request_i, primary_osc_input_i, bidir_processor_clock_i, external_clock_input_i, gpio9_out_i;
  reg gpio9_oe_n_i, gpio10_out_i, gpio10_oe_n_i, gpio3_out_i, gpio3_oe_n_i, gpio4_out_i, gpio4_oe_n_i;
  reg power_bus_clock_out_i, power_bus_clock_oe_n_i, power_bus_data_out_i, power_bus_data_oe_n_i;
  reg power_bus_clock_pin_i, power_bus_data_pin_i, battery_low, supply_bad, level;
  reg [2:0] mode_request_i;
  reg [`FAULT_CTRL_WIDTH-1:0] fault_handling_control_i;
  reg [`WAKE_PIN_COUNT-1:0] wake_enable_i, wake_pins_i;
  wire battery_fault_n_i, supply_fault_n_i, slow_osc_input_i;
  wire [2:0] power_mode_o;
  wire wake_event_o, fault_wake_only_o, hold_pull_resistors_o, wake_pulls_enable_o, slow_clock_pull_down_o;
  wire pin_reset_request_o, gpio1_to_gpio_o, reset_out_n_o, processor_osc_clock_o, bidir_processor_clock_o;
  wire bidir_processor_clock_oe_n_o, gpio9_pin_o, gpio9_pin_oe_n_o, slow_clock_out_o, slow_clock_out_oe_n_o;
  wire clock_source_pad_o, external_clock_usable_o, core_supply_enable_o, system_supply_enable_o;
  wire power_bus_clock_o, power_bus_clock_oe_n_o, power_bus_data_o, power_bus_data_oe_n_o, power_bus_clock_in_o;
  wire power_bus_data_in_o, gpio3_in_o, gpio4_in_o, debug_clock_out_o;
  integer mismatches, compares, m, i, n;

  power_pin_wake_control u_dut (.*);
  board_partner_model u_board (.clock_i(clock_i), .battery_low_i(battery_low), .supply_bad_i(supply_bad),
    .battery_fault_n_o(battery_fault_n_i), .supply_fault_n_o(supply_fault_n_i), .slow_osc_o(slow_osc_input_i));

  // Free running 10 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task check(input [63:0] seen, input [63:0] exp, input [8*16-1:0] name);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("Error %0s expected %0h seen %0h", name, exp, seen);
    end
  end
  endtask

  // Reads happen 1 ns after the edge so registered outputs have settled
  task wait_cycles(input integer k);
  begin
    repeat (k) @(posedge clock_i);
    #1;
  end
  endtask

  task request_mode(input [2:0] md);
  begin
    @(posedge clock_i);
    mode_request_i <= md;
    mode_request_valid_i <= 1'b1;
    @(posedge clock_i);
    mode_request_valid_i <= 1'b0;
  end
  endtask

  // Bounded wait, since the synchronisers add a lag of a few edges
  task wait_mode(input [2:0] exp);
  begin
    for (i = 0; i < 12 && power_mode_o !== exp; i = i + 1)
      wait_cycles(1);
    check(power_mode_o, exp, "power_mode");
  end
  endtask

  // Wake is edge sensitive, so the pin goes up and back down
  task pulse_pin(input integer idx);
  begin
    @(posedge clock_i);
    wake_pins_i[idx] <= 1'b1;
    wait_cycles(8);
    @(posedge clock_i);
    wake_pins_i[idx] <= 1'b0;
    wait_cycles(8);
  end
  endtask

  task tally_and_finish;
  begin
    $display("Checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clock_i);
    mismatches = mismatches + 1;
    tally_and_finish;
  end

  initial
  begin
    {rst_n_i, reset_any_i, reset_hard_i, mode_request_valid_i, hold_pull_resistors_clear_i, pin_reset_enable_i,
      pin_reset_out_disable_i, clock_from_pad_select_i, clock_pin_enable_i, slow_clock_out_enable_i} = 10'h0;
    {power_bus_enable_i, debug_clock_enable_i, primary_osc_input_i, bidir_processor_clock_i,
      external_clock_input_i, gpio9_out_i, gpio10_out_i, gpio3_out_i, gpio4_out_i} = 9'h0;
    {power_bus_clock_out_i, power_bus_data_out_i, battery_low, supply_bad, mode_request_i,
      fault_handling_control_i} = 9'h0;
    {gpio1_pin_i, clock_request_i, gpio9_oe_n_i, gpio10_oe_n_i, gpio3_oe_n_i, gpio4_oe_n_i, power_bus_clock_oe_n_i,
      power_bus_data_oe_n_i, power_bus_clock_pin_i, power_bus_data_pin_i, os_timer_running_i} = 11'h7ff;
    wake_enable_i = `WAKE_PIN_MASK_ALL;
    wake_pins_i = {`WAKE_PIN_COUNT{1'b0}};
    mismatches = 0;
    compares = 0;
    wait_cycles(1);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    wait_cycles(5);
    check(core_supply_enable_o & system_supply_enable_o, 1, "supplies_run");
    check(wake_pulls_enable_o & slow_clock_pull_down_o, 1, "pulls_reset");
    check(external_clock_usable_o, 1, "ext_clock_run");
    // Pull release, then a reset puts the pulls back
    @(posedge clock_i);
    hold_pull_resistors_clear_i <= 1'b1;
    @(posedge clock_i);
    hold_pull_resistors_clear_i <= 1'b0;
    wait_cycles(2);
    check({wake_pulls_enable_o, slow_clock_pull_down_o}, 0, "pulls_free");
    @(posedge clock_i);
    reset_any_i <= 1'b1;
    wait_cycles(3);
    check(wake_pulls_enable_o, 1, "pulls_again");
    @(posedge clock_i);
    reset_any_i <= 1'b0;
    // Strap is sampled only during a hard reset
    clock_request_i <= 1'b1;
    wait_cycles(3);
    check(clock_source_pad_o, 1, "strap_ignored");
    @(posedge clock_i);
    reset_hard_i <= 1'b1;
    wait_cycles(3);
    check(clock_source_pad_o, 0, "strap_taken");
    @(posedge clock_i);
    reset_hard_i <= 1'b0;
    // Pin sharing with every owner enabled
    power_bus_enable_i <= 1'b1;
    clock_pin_enable_i <= 1'b1;
    slow_clock_out_enable_i <= 1'b1;
    power_bus_clock_pin_i <= 1'b0;
    power_bus_data_oe_n_i <= 1'b0;
    gpio9_oe_n_i <= 1'b0;
    gpio4_oe_n_i <= 1'b0;
    power_bus_data_pin_i <= 1'b0;
    wait_cycles(3);
    check({gpio9_pin_oe_n_o, bidir_processor_clock_oe_n_o}, 2'h2, "clock_pin_owner");
    check({power_bus_clock_in_o, gpio3_in_o}, 2'h1, "scl_routing");
    check(power_bus_data_oe_n_o, 0, "sda_drive");
    check(slow_clock_out_oe_n_o, 0, "slow_out_drive");
    level = slow_clock_out_o;
    wait_cycles(1);
    check(slow_clock_out_o, !level, "slow_out_moves");
    @(posedge clock_i);
    clock_from_pad_select_i <= 1'b1;
    clock_pin_enable_i <= 1'b0;
    bidir_processor_clock_i <= 1'b1;
    wait_cycles(3);
    check({processor_osc_clock_o, gpio9_pin_oe_n_o}, 2'h3, "clock_from_pin");
    @(posedge clock_i);
    clock_from_pad_select_i <= 1'b0;
    power_bus_enable_i <= 1'b0;
    power_bus_data_oe_n_i <= 1'b1;
    wait_cycles(3);
    check({processor_osc_clock_o, gpio9_pin_oe_n_o}, 0, "clock_from_pad");
    check({power_bus_data_oe_n_o, gpio4_in_o}, 2'h0, "gpio4_back");
    // Pin reset and its reset-out indication
    @(posedge clock_i);
    pin_reset_enable_i <= 1'b1;
    gpio1_pin_i <= 1'b0;
    wait_cycles(6);
    check({pin_reset_request_o, gpio1_to_gpio_o, reset_out_n_o}, 3'h4, "pin_reset");
    @(posedge clock_i);
    pin_reset_out_disable_i <= 1'b1;
    wait_cycles(3);
    check(reset_out_n_o, 1, "reset_out_off");
    @(posedge clock_i);
    gpio1_pin_i <= 1'b1;
    pin_reset_enable_i <= 1'b0;
    pin_reset_out_disable_i <= 1'b0;
    wait_cycles(6);
    // Standby and sleep wake on a general pin
    for (m = 1; m < 3; m = m + 1)
    begin
      request_mode(m);
      wait_mode(m);
      check({core_supply_enable_o, system_supply_enable_o}, {m == 1, 1'b1}, "supplies_low");
      check(external_clock_usable_o, 0, "ext_clock_timer");
      pulse_pin(5);
      check(power_mode_o, `MODE_RUN, "general_wake");
    end
    // Deep sleep refuses a general pin and takes GPIO 3
    request_mode(`MODE_DEEP_SLEEP);
    wait_mode(`MODE_DEEP_SLEEP);
    check({core_supply_enable_o, system_supply_enable_o, slow_clock_out_o}, 0, "deep_outputs");
    pulse_pin(5);
    check(power_mode_o, `MODE_DEEP_SLEEP, "deep_refuse");
    pulse_pin(2);
    check(power_mode_o, `MODE_RUN, "gpio3_wake");
    // Fault entry: only GPIO 1 and 0 may wake afterwards
    @(posedge clock_i);
    battery_low <= 1'b1;
    wait_mode(`MODE_DEEP_SLEEP);
    check(fault_wake_only_o, 1, "fault_only");
    @(posedge clock_i);
    battery_low <= 1'b0;
    pulse_pin(2);
    check(power_mode_o, `MODE_DEEP_SLEEP, "fault_refuse");
    pulse_pin(0);
    check(power_mode_o, `MODE_RUN, "fault_wake");
    // Nonzero fault control leaves the mode alone
    @(posedge clock_i);
    fault_handling_control_i <= 2'h1;
    supply_bad <= 1'b1;
    wait_cycles(10);
    check(power_mode_o, `MODE_RUN, "fault_masked");
    @(posedge clock_i);
    supply_bad <= 1'b0;
    debug_clock_enable_i <= 1'b1;
    wait_cycles(2);
    // Debug clock high phase is half the divide ratio
    for (i = 0; i < 20 && debug_clock_out_o !== 1'b1; i = i + 1)
      wait_cycles(1);
    for (n = 0; n < 20 && debug_clock_out_o === 1'b1; n = n + 1)
      wait_cycles(1);
    check(n, `DEBUG_DIV_HALF, "debug_half");
    tally_and_finish;
  end
endmodule
